//--- logic/tdm_port_regs.svh
`ifndef TDM_PORT_REGS_SVH
`define TDM_PORT_REGS_SVH

// Register byte offsets on the Wishbone bus.
`define PORT_CFG_OFF 8'h00
`define RST_CTRL_OFF 8'h2C
`define TDM_FILL_OFF 8'h30
`define PKT_FILL_OFF 8'h34

// Reset values and writable masks.
`define PORT_CFG_RST 7'h51
`define PORT_CFG_MASK 32'h0000_007F
`define RST_CTRL_RST 32'h0000_0000
`define RST_CTRL_MASK 32'h0FFF_007F
`define FILL_RST 32'h0000_0000

// Field positions in the reset control register.
`define RST_TX_REQ_BIT 16
`define RST_RX_REQ_BIT 0

// Last bit index of an octet on the serial port.
`define OCTET_LAST 3'h7

`endif

//--- logic/tdm_port_pkg.sv
package tdm_port_pkg;

  typedef enum logic [1:0] {
    FRM_UNFRAMED = 2'b00,
    FRM_FRAME = 2'b01,
    FRM_MULTI = 2'b10,
    FRM_ESF = 2'b11
  } framing_t;

  typedef enum logic [1:0] {
    IF_SERIAL = 2'b00,
    IF_E1 = 2'b01,
    IF_T1 = 2'b10,
    IF_RSVD = 2'b11
  } iface_t;

  typedef enum logic [1:0] {
    KIND_AAL1 = 2'b00,
    KIND_SATOP = 2'b01,
    KIND_CESOPSN = 2'b10,
    KIND_HDLC = 2'b11
  } bundle_kind_t;

  typedef struct packed {
    logic rx_edge;
    logic tx_edge;
    logic two_clocks;
    framing_t framing;
    iface_t iface;
  } port_cfg_t;

  typedef struct packed {
    logic [3:0] rsvd_hi;
    logic [3:0] tx_port;
    logic [5:0] tx_bundle;
    logic tx_open;
    logic tx_req;
    logic [8:0] rsvd_lo;
    logic [5:0] rx_bundle;
    logic rx_req;
  } rst_ctrl_t;

endpackage : tdm_port_pkg

//--- logic/port_edge_io.sv
`timescale 1ns/10ps
module port_edge_io #(
  parameter int DW = 1
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Pins from the port.
  input wire logic clk_pin_i,
  input wire logic [DW-1:0] data_pin_i,
  // Synchronised view.
  output logic rise_o,
  output logic fall_o,
  output logic [DW-1:0] data_o
);

  logic [DW:0] meta_q;
  logic [DW:0] sync_q;
  logic clk_prev_q;

  // Two flip-flops guard every pin before any logic reads it.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
      clk_prev_q <= 1'b0;
    end else begin
      meta_q <= {clk_pin_i, data_pin_i};
      sync_q <= meta_q;
      clk_prev_q <= sync_q[DW];
    end
  end

  assign rise_o = sync_q[DW] & ~clk_prev_q;
  assign fall_o = ~sync_q[DW] & clk_prev_q;
  assign data_o = sync_q[DW-1:0];

endmodule : port_edge_io

//--- logic/tdm_port_cond_regs.sv
// Summary of operation
// - Two-clock mode: transmit edge bit picks transmit sample and update edges.
// - Edge bit 0 samples falling, updates rising; 1 samples rising, updates falling.
// - Clock-mode bit 0 uses transmit clock only; 1 adds receive clock; resets 1.
// - Framing field: unframed, frame sync, multiframe/superframe, extended superframe.
// - Interface field: serial, E1, T1, reserved; resets to E1.
// - Four-bit field names the port, codes 0 to 7 for ports one to eight.
// - Bits 23 to 18 name the bundle for a transmit reset.
// - Open/close bit counts only with a transmit request; 1 means open.
// - Transmit request resets the payload machine; device clears it when done.
// - Writing 1 to the receive request asks for a reset frame; ack clears it.
// - On underrun the four TDM fill octets go to the port.
// - TDM fill register: octet A in bits 31 to 24, D in 7 to 0.
// - Packet fill octets go out for AAL1, SAToP, CESoPSN when data is missing.
// - Per-bundle setting selects which packet fill octet is used.
// - Packet fill register: octet A in bits 7 to 0, D in 31 to 24.
// - In high-speed operation the first TDM fill octet is the underrun fill.
// - Two-clock mode: receive edge bit 0 samples falling, 1 rising.
// - One-clock mode: transmit edge bit governs all sampling on the transmit clock.
`timescale 1ns/10ps
module tdm_port_cond_regs (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Port pins.
  input wire logic port_tx_clock_pin_i,
  input wire logic port_rx_clock_pin_i,
  input wire logic port_tx_sync_in_i,
  input wire logic port_tx_mfsync_carrier_pin_i,
  input wire logic port_rx_data_in_i,
  output logic port_tx_data_out_o,
  output logic port_tx_signalling_cts_pin_o,
  // TDM-direction data.
  input wire logic [7:0] tdm_octet_i,
  input wire logic underrun_i,
  input wire logic tx_sig_i,
  input wire logic high_speed_i,
  output logic tdm_octet_take_o,
  output logic mf_start_o,
  // Packet-direction data.
  input wire logic pkt_req_i,
  input wire tdm_port_pkg::bundle_kind_t pkt_kind_i,
  input wire logic [1:0] pkt_octet_sel_i,
  output logic pkt_valid_o,
  output logic pkt_fill_o,
  output logic [7:0] pkt_octet_o,
  // Reset requests.
  output logic tx_reset_req_o,
  output logic [3:0] tx_reset_port_o,
  output logic [5:0] tx_reset_bundle_o,
  output logic tx_reset_open_o,
  input wire logic tx_reset_ack_i,
  output logic rx_reset_req_o,
  output logic [5:0] rx_reset_bundle_o,
  input wire logic rx_reset_ack_i,
  // Configuration.
  output tdm_port_pkg::port_cfg_t port_cfg_o
);

`include "tdm_port_regs.svh"

  tdm_port_pkg::port_cfg_t cfg_q;
  tdm_port_pkg::rst_ctrl_t rst_q;
  tdm_port_pkg::rst_ctrl_t rst_new;
  logic [31:0] tdm_fill_q;
  logic [31:0] pkt_fill_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic tx_rise;
  logic tx_fall;
  logic rx_rise;
  logic rx_fall;
  logic [2:0] tx_dat;
  logic rx_data_rx;
  logic tx_samp;
  logic tx_upd;
  logic rx_samp;
  logic rx_bit;
  logic tx_sync_now;
  logic wb_req;
  logic wb_wr;
  logic tx_set_w;
  logic rx_set_w;
  logic [31:0] cfg_wr;
  logic [31:0] rst_wr;
  logic [31:0] tdm_wr;
  logic [31:0] pkt_wr;
  logic [7:0] tx_shift_q;
  logic [2:0] tx_cnt_q;
  logic [1:0] fill_idx_q;
  logic [1:0] fill_use;
  logic [7:0] tdm_fill_oct;
  logic [7:0] new_octet;
  logic tx_out_q;
  logic tx_sig_q;
  logic take_q;
  logic mf_q;
  logic [7:0] rx_sh_q;
  logic [2:0] rx_cnt_q;
  logic [7:0] rx_hold_q;
  logic rx_have_q;
  logic cond_kind;
  logic [7:0] pkt_fill_oct;
  logic pkt_valid_q;
  logic pkt_fill_q2;
  logic [7:0] pkt_oct_q;

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  port_edge_io #(.DW(3)) u_tx_edge (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .clk_pin_i(port_tx_clock_pin_i),
    .data_pin_i({port_rx_data_in_i, port_tx_mfsync_carrier_pin_i, port_tx_sync_in_i}),
    .rise_o(tx_rise),
    .fall_o(tx_fall),
    .data_o(tx_dat)
  );

  port_edge_io #(.DW(1)) u_rx_edge (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .clk_pin_i(port_rx_clock_pin_i),
    .data_pin_i(port_rx_data_in_i),
    .rise_o(rx_rise),
    .fall_o(rx_fall),
    .data_o(rx_data_rx)
  );

  // Edge selection for sampling and updating.
  assign tx_samp = cfg_q.tx_edge ? tx_rise : tx_fall;
  assign tx_upd = cfg_q.tx_edge ? tx_fall : tx_rise;
  assign rx_samp = cfg_q.two_clocks ? (cfg_q.rx_edge ? rx_rise : rx_fall) : tx_samp;
  assign rx_bit = cfg_q.two_clocks ? rx_data_rx : tx_dat[2];
  assign tx_sync_now = tx_samp & tx_dat[0] & (cfg_q.framing != tdm_port_pkg::FRM_UNFRAMED);

  // Bus decode and byte-lane merge; a write lands at the edge on which the master sees ack.
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
  assign cfg_wr = lane_merge({25'h0, cfg_q}, wb_dat_i, wb_sel_i) & `PORT_CFG_MASK;
  assign rst_wr = lane_merge(rst_q, wb_dat_i, wb_sel_i) & `RST_CTRL_MASK;
  assign tdm_wr = lane_merge(tdm_fill_q, wb_dat_i, wb_sel_i);
  assign pkt_wr = lane_merge(pkt_fill_q, wb_dat_i, wb_sel_i);
  assign rst_new = tdm_port_pkg::rst_ctrl_t'(rst_wr);
  assign tx_set_w = wb_wr & (wb_adr_i == `RST_CTRL_OFF) & wb_sel_i[2] & wb_dat_i[`RST_TX_REQ_BIT];
  assign rx_set_w = wb_wr & (wb_adr_i == `RST_CTRL_OFF) & wb_sel_i[0] & wb_dat_i[`RST_RX_REQ_BIT];

  // Bus answer one cycle after the request; unmapped reads return zero.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= wb_req;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `PORT_CFG_OFF: rdata_q <= {25'h0, cfg_q};
          `RST_CTRL_OFF: rdata_q <= rst_q;
          `TDM_FILL_OFF: rdata_q <= tdm_fill_q;
          `PKT_FILL_OFF: rdata_q <= pkt_fill_q;
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Port configuration register.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_q <= tdm_port_pkg::port_cfg_t'(`PORT_CFG_RST);
    end else if (wb_wr && wb_adr_i == `PORT_CFG_OFF) begin
      cfg_q <= tdm_port_pkg::port_cfg_t'(cfg_wr[6:0]);
    end
  end

  // Reset control register; a new request wins over an acknowledge in the same cycle.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_q <= tdm_port_pkg::rst_ctrl_t'(`RST_CTRL_RST);
    end else begin
      if (tx_reset_ack_i) begin
        rst_q.tx_req <= 1'b0;
      end
      if (rx_reset_ack_i) begin
        rst_q.rx_req <= 1'b0;
      end
      if (wb_wr && wb_adr_i == `RST_CTRL_OFF) begin
        rst_q.tx_port <= rst_new.tx_port;
        rst_q.tx_bundle <= rst_new.tx_bundle;
        rst_q.tx_open <= rst_new.tx_open;
        rst_q.rx_bundle <= rst_new.rx_bundle;
      end
      if (tx_set_w) begin
        rst_q.tx_req <= 1'b1;
      end
      if (rx_set_w) begin
        rst_q.rx_req <= 1'b1;
      end
    end
  end

  // Conditioning pattern registers.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tdm_fill_q <= `FILL_RST;
      pkt_fill_q <= `FILL_RST;
    end else if (wb_wr) begin
      if (wb_adr_i == `TDM_FILL_OFF) begin
        tdm_fill_q <= tdm_wr;
      end
      if (wb_adr_i == `PKT_FILL_OFF) begin
        pkt_fill_q <= pkt_wr;
      end
    end
  end

  // Octet A sits at the top of the TDM pattern; high-speed mode repeats it.
  assign fill_use = high_speed_i ? 2'b00 : fill_idx_q;
  assign tdm_fill_oct = tdm_fill_q[{~fill_use, 3'b000} +: 8];
  assign new_octet = underrun_i ? tdm_fill_oct : tdm_octet_i;

  // Transmit serializer, most significant bit first.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_shift_q <= 8'h00;
      tx_cnt_q <= 3'h0;
      fill_idx_q <= 2'h0;
      tx_out_q <= 1'b1;
      tx_sig_q <= 1'b1;
      take_q <= 1'b0;
    end else begin
      take_q <= 1'b0;
      if (tx_sync_now) begin
        tx_cnt_q <= 3'h0;
      end else if (tx_upd) begin
        tx_cnt_q <= tx_cnt_q + 3'h1;
        tx_sig_q <= tx_sig_i;
        if (tx_cnt_q == 3'h0) begin
          tx_shift_q <= new_octet;
          tx_out_q <= new_octet[7];
          if (underrun_i) begin
            fill_idx_q <= fill_idx_q + 2'h1;
          end else begin
            take_q <= 1'b1;
          end
        end else begin
          tx_out_q <= tx_shift_q[~tx_cnt_q];
        end
      end
    end
  end

  // Multiframe sync is sampled only for multiframe and extended superframe framing.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mf_q <= 1'b0;
    end else begin
      mf_q <= tx_samp & tx_dat[1] & cfg_q.framing[1];
    end
  end

  // Receive deserializer.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_sh_q <= 8'h00;
      rx_cnt_q <= 3'h0;
      rx_hold_q <= 8'h00;
    end else if (rx_samp) begin
      rx_sh_q <= {rx_sh_q[6:0], rx_bit};
      rx_cnt_q <= rx_cnt_q + 3'h1;
      if (rx_cnt_q == `OCTET_LAST) begin
        rx_hold_q <= {rx_sh_q[6:0], rx_bit};
      end
    end
  end

  // A finished octet outranks consumption in the same cycle.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_have_q <= 1'b0;
    end else if (rx_samp && rx_cnt_q == `OCTET_LAST) begin
      rx_have_q <= 1'b1;
    end else if (pkt_req_i) begin
      rx_have_q <= 1'b0;
    end
  end

  // Packet direction answer, with fill octets for non-HDLC bundles when no port data waits.
  assign cond_kind = pkt_kind_i != tdm_port_pkg::KIND_HDLC;
  assign pkt_fill_oct = pkt_fill_q[{pkt_octet_sel_i, 3'b000} +: 8];

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pkt_valid_q <= 1'b0;
      pkt_fill_q2 <= 1'b0;
      pkt_oct_q <= 8'h00;
    end else begin
      pkt_valid_q <= pkt_req_i & (rx_have_q | cond_kind);
      pkt_fill_q2 <= pkt_req_i & ~rx_have_q & cond_kind;
      if (pkt_req_i) begin
        pkt_oct_q <= rx_have_q ? rx_hold_q : (cond_kind ? pkt_fill_oct : 8'h00);
      end
    end
  end

  assign wb_dat_o = rdata_q;
  assign wb_ack_o = ack_q;
  assign port_tx_data_out_o = tx_out_q;
  assign port_tx_signalling_cts_pin_o = tx_sig_q;
  assign tdm_octet_take_o = take_q;
  assign mf_start_o = mf_q;
  assign pkt_valid_o = pkt_valid_q;
  assign pkt_fill_o = pkt_fill_q2;
  assign pkt_octet_o = pkt_oct_q;
  assign tx_reset_req_o = rst_q.tx_req;
  assign tx_reset_port_o = rst_q.tx_port;
  assign tx_reset_bundle_o = rst_q.tx_bundle;
  assign tx_reset_open_o = rst_q.tx_open;
  assign rx_reset_req_o = rst_q.rx_req;
  assign rx_reset_bundle_o = rst_q.rx_bundle;
  assign port_cfg_o = cfg_q;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_bus_req;
    wb_req;
  endsequence
  sequence s_rx_ack;
    rx_reset_ack_i && rx_reset_req_o && !rx_set_w;
  endsequence
  sequence s_tx_ack;
    tx_reset_ack_i && tx_reset_req_o && !tx_set_w;
  endsequence
  sequence s_fill_req;
    pkt_req_i && !rx_have_q && cond_kind;
  endsequence

  property p_wb_ack;
    s_bus_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bus ack not a single pulse.");

  property p_rx_set;
    rx_set_w |=> rx_reset_req_o && rx_reset_bundle_o == $past(wb_dat_i[6:1]);
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("receive reset request not taken.");

  property p_rx_clear;
    s_rx_ack |=> !rx_reset_req_o;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("receive request not cleared.");

  property p_tx_set;
    tx_set_w |=> tx_reset_req_o && tx_reset_bundle_o == $past(rst_wr[23:18]);
  endproperty
  a_tx_set: assert property (p_tx_set) else $error("transmit reset request not taken.");

  property p_tx_clear;
    s_tx_ack |=> !tx_reset_req_o;
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("transmit request not cleared.");

  property p_tx_upd_edge;
    $changed(tx_cnt_q) && !$past(tx_sync_now) |-> $past(tx_upd);
  endproperty
  a_tx_upd_edge: assert property (p_tx_upd_edge) else $error("serializer moved off its edge.");

  property p_tx_rise_upd;
    tx_rise && !cfg_q.tx_edge && !tx_sync_now |=> tx_cnt_q == 3'($past(tx_cnt_q) + 3'h1);
  endproperty
  a_tx_rise_upd: assert property (p_tx_rise_upd) else $error("edge bit 0 must update on rise.");

  property p_rx_two_clk;
    rx_rise && cfg_q.two_clocks && cfg_q.rx_edge |=> rx_sh_q[0] == $past(rx_data_rx);
  endproperty
  a_rx_two_clk: assert property (p_rx_two_clk) else $error("receive not sampled on rise.");

  property p_rx_one_clk;
    tx_fall && !cfg_q.two_clocks && !cfg_q.tx_edge |=> rx_sh_q[0] == $past(tx_dat[2]);
  endproperty
  a_rx_one_clk: assert property (p_rx_one_clk) else $error("one-clock receive sampling wrong.");

  property p_sync;
    tx_sync_now |=> tx_cnt_q == 3'h0;
  endproperty
  a_sync: assert property (p_sync) else $error("frame sync did not realign.");

  property p_fill_hs;
    tx_upd && !tx_sync_now && tx_cnt_q == 3'h0 && underrun_i && high_speed_i
      |=> tx_shift_q == $past(tdm_fill_q[31:24]);
  endproperty
  a_fill_hs: assert property (p_fill_hs) else $error("high-speed fill not octet A.");

  property p_fill_seq;
    tx_upd && !tx_sync_now && tx_cnt_q == 3'h0 && underrun_i
      |=> tx_shift_q == $past(tdm_fill_oct) && fill_idx_q == 2'($past(fill_idx_q) + 2'h1);
  endproperty
  a_fill_seq: assert property (p_fill_seq) else $error("underrun fill octet wrong.");

  property p_pkt_fill;
    s_fill_req |=> pkt_valid_o && pkt_fill_o && pkt_octet_o == $past(pkt_fill_oct);
  endproperty
  a_pkt_fill: assert property (p_pkt_fill) else $error("packet fill octet wrong.");

  property p_pkt_hdlc;
    pkt_req_i && !rx_have_q && !cond_kind |=> !pkt_valid_o;
  endproperty
  a_pkt_hdlc: assert property (p_pkt_hdlc) else $error("fill sent for excluded bundle.");

endmodule : tdm_port_cond_regs

//--- test/tdm_framer_model.sv
`timescale 1ns/10ps
module tdm_framer_model (
  // Core clock and controls.
  input wire logic core_clk_i,
  input wire logic sample_on_rise_i,
  input wire logic rx_run_i,
  // Port pins.
  input wire logic tx_data_i,
  output logic tx_clk_o,
  output logic rx_clk_o,
  output logic sync_o,
  output logic mf_o,
  output logic rx_data_o,
  // Observations.
  output logic [15:0] stream_o,
  output logic [7:0] gap_o
);
  logic [3:0] div_q = 4'h0;
  logic [4:0] bit_q = 5'h00;
  logic [7:0] since_q = 8'h00;
  logic clk_q = 1'b0;
  logic last_q = 1'b1;
  logic [7:0] pat_q = 8'h96;
  initial stream_o = 16'h0000;
  initial gap_o = 8'h00;
  // The transmit clock runs free; the receive clock stands still unless asked for.
  assign tx_clk_o = div_q[3];
  assign rx_clk_o = rx_run_i & div_q[3];
  assign rx_data_o = pat_q[7];
  assign sync_o = (bit_q[2:0] == 3'h0);
  assign mf_o = (bit_q == 5'h00);
  always @(posedge core_clk_i) begin
    div_q <= div_q + 4'h1;
    clk_q <= div_q[3];
    since_q <= (div_q[3] & ~clk_q) ? 8'h00 : since_q + 8'h01;
    if (div_q == 4'h7) bit_q <= bit_q + 5'h01;
    if (div_q == 4'h3) pat_q <= {pat_q[6:0], pat_q[7]};
    if (tx_data_i !== last_q) gap_o <= since_q;
    last_q <= tx_data_i;
    if ((div_q[3] ^ clk_q) && (div_q[3] == sample_on_rise_i)) stream_o <= {stream_o[14:0], tx_data_i};
  end
endmodule : tdm_framer_model

//--- test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  // Bus and control inputs.
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [7:0] tdm_octet_i = 8'h01;
  logic underrun_i = 1'b0;
  logic tx_sig_i = 1'b0;
  logic high_speed_i = 1'b0;
  logic pkt_req_i = 1'b0;
  tdm_port_pkg::bundle_kind_t pkt_kind_i = tdm_port_pkg::KIND_AAL1;
  logic [1:0] pkt_octet_sel_i = 2'h0;
  logic tx_reset_ack_i = 1'b0;
  logic rx_reset_ack_i = 1'b0;
  logic sample_on_rise = 1'b0;
  logic rx_run = 1'b0;
  // Observed outputs.
  logic [31:0] wb_dat_o;
  logic wb_ack_o, tclk, rclk, tsync, tmf, rxd, txd, cts, take, mf_start, pvalid, pfill, txr_req, txr_open, rxr_req;
  logic [7:0] poct, gap;
  logic [15:0] stream;
  logic [3:0] txr_port;
  logic [5:0] txr_bundle, rxr_bundle;
  tdm_port_pkg::port_cfg_t cfg;
  logic [31:0] rd;
  int fail_count = 0;
  int checks_done = 0;
  int ntake, nmf;

  always #20 core_clk_i = ~core_clk_i;

  tdm_port_cond_regs u_tdm_port_cond_regs (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_tx_clock_pin_i(tclk), .port_rx_clock_pin_i(rclk),
    .port_tx_sync_in_i(tsync), .port_tx_mfsync_carrier_pin_i(tmf), .port_rx_data_in_i(rxd),
    .port_tx_data_out_o(txd), .port_tx_signalling_cts_pin_o(cts), .tdm_octet_i(tdm_octet_i),
    .underrun_i(underrun_i), .tx_sig_i(tx_sig_i), .high_speed_i(high_speed_i), .tdm_octet_take_o(take),
    .mf_start_o(mf_start), .pkt_req_i(pkt_req_i), .pkt_kind_i(pkt_kind_i), .pkt_octet_sel_i(pkt_octet_sel_i),
    .pkt_valid_o(pvalid), .pkt_fill_o(pfill), .pkt_octet_o(poct), .tx_reset_req_o(txr_req),
    .tx_reset_port_o(txr_port), .tx_reset_bundle_o(txr_bundle), .tx_reset_open_o(txr_open),
    .tx_reset_ack_i(tx_reset_ack_i), .rx_reset_req_o(rxr_req), .rx_reset_bundle_o(rxr_bundle),
    .rx_reset_ack_i(rx_reset_ack_i), .port_cfg_o(cfg));

  tdm_framer_model u_tdm_framer_model (.core_clk_i(core_clk_i), .sample_on_rise_i(sample_on_rise),
    .rx_run_i(rx_run), .tx_data_i(txd), .tx_clk_o(tclk), .rx_clk_o(rclk), .sync_o(tsync), .mf_o(tmf),
    .rx_data_o(rxd), .stream_o(stream), .gap_o(gap));

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    int n;
    @(posedge core_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      chk("bus ack", 32'h1, 32'h0);
      tally_and_finish();
    end
    @(posedge core_clk_i);
  endtask : wb

  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0, 4'hF);
    chk("read data", exp, rd);
  endtask : rdchk

  task automatic run(input int cycles);
    ntake = 0;
    nmf = 0;
    repeat (cycles) begin
      @(posedge core_clk_i);
      ntake += (take === 1'b1);
      nmf += (mf_start === 1'b1);
    end
  endtask : run

  task automatic reset_dut();
    @(posedge core_clk_i);
    reset_n_i <= 1'b0;
    repeat (5) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
  endtask : reset_dut

  task automatic pkt(input tdm_port_pkg::bundle_kind_t k, input logic [1:0] s, input logic v, input logic f,
                     input logic [7:0] o);
    @(posedge core_clk_i);
    pkt_req_i <= 1'b1;
    pkt_kind_i <= k;
    pkt_octet_sel_i <= s;
    @(posedge core_clk_i);
    pkt_req_i <= 1'b0;
    #1;
    chk("pkt valid", v, pvalid);
    chk("pkt fill", f, pfill);
    if (f) chk("pkt octet", o, poct);
  endtask : pkt

  task automatic chk_stream(input logic [4:0] ones);
    chk("stream period", stream[15:8], stream[7:0]);
    chk("stream ones", ones, $countones(stream));
  endtask : chk_stream

  task automatic s_reset_values();
    chk("cfg out", 32'h51, cfg);
    chk("tx data reset", 32'h1, txd);
    chk("cts reset", 32'h1, cts);
    rdchk(8'h00, 32'h51);
    rdchk(8'h2C, 32'h0);
    rdchk(8'h30, 32'h0);
    rdchk(8'h34, 32'h0);
    wb(1'b1, 8'h10, 32'hFFFF_FFFF, 4'hF);
    rdchk(8'h10, 32'h0);
  endtask : s_reset_values

  task automatic s_fill_regs();
    wb(1'b1, 8'h30, 32'h0F00_5AC3, 4'hF);
    rdchk(8'h30, 32'h0F00_5AC3);
    wb(1'b1, 8'h34, 32'h4433_2211, 4'hF);
    wb(1'b1, 8'h34, 32'hFFFF_FFFF, 4'h2);
    rdchk(8'h34, 32'h4433_FF11);
    for (int k = 0; k < 3; k++) pkt(tdm_port_pkg::bundle_kind_t'(k), 2'(k), 1'b1, 1'b1, 8'(32'h4433_FF11 >> (8 * k)));
    pkt(tdm_port_pkg::KIND_SATOP, 2'h3, 1'b1, 1'b1, 8'h44);
    pkt(tdm_port_pkg::KIND_HDLC, 2'h0, 1'b0, 1'b0, 8'h00);
  endtask : s_fill_regs

  task automatic s_tx_reset();
    int n;
    wb(1'b1, 8'h2C, 32'h07AB_0000, 4'hF);
    chk("tx req", 32'h1, txr_req);
    chk("tx port", 32'h7, txr_port);
    chk("tx bundle", 32'h2A, txr_bundle);
    chk("tx open", 32'h1, txr_open);
    wb(1'b1, 8'h2C, 32'h07AA_002B, 4'hF);
    chk("tx req held", 32'h1, txr_req);
    chk("rx req", 32'h1, rxr_req);
    chk("rx bundle", 32'h15, rxr_bundle);
    rdchk(8'h2C, 32'h07AB_002B);
    @(posedge core_clk_i);
    tx_reset_ack_i <= 1'b1;
    rx_reset_ack_i <= 1'b1;
    @(posedge core_clk_i);
    tx_reset_ack_i <= 1'b0;
    rx_reset_ack_i <= 1'b0;
    n = 0;
    do begin
      wb(1'b0, 8'h2C, 32'h0, 4'hF);
      n++;
    end while ((rd & 32'h0001_0001) != 32'h0 && n < 8);
    chk("reset reg", 32'h07AA_002A, rd);
    chk("tx req cleared", 32'h0, txr_req);
    chk("rx req cleared", 32'h0, rxr_req);
  endtask : s_tx_reset

  task automatic s_serial();
    high_speed_i <= 1'b1;
    underrun_i <= 1'b1;
    run(512);
    chk_stream(5'h08);
    chk("cts", 32'h0, cts);
    chk("update on rise", 32'h1, gap < 8'h08);
    chk("mf unframed", 32'h0, nmf);
    high_speed_i <= 1'b0;
    underrun_i <= 1'b0;
    tx_sig_i <= 1'b1;
    run(64);
    run(512);
    chk("takes", 32'h4, ntake);
    chk_stream(5'h02);
    chk("cts high", 32'h1, cts);
    tx_sig_i <= 1'b0;
    wb(1'b1, 8'h00, 32'h71, 4'hF);
    sample_on_rise <= 1'b1;
    run(512);
    chk_stream(5'h02);
    chk("update on fall", 32'h1, gap >= 8'h08);
    wb(1'b1, 8'h30, 32'h7E7E_7E7E, 4'hF);
    underrun_i <= 1'b1;
    run(512);
    chk_stream(5'h0C);
    underrun_i <= 1'b0;
  endtask : s_serial

  task automatic s_framing();
    wb(1'b1, 8'h00, 32'h59, 4'hF);
    sample_on_rise <= 1'b0;
    chk("cfg write", 32'h59, cfg);
    run(600);
    chk("mf seen", 32'h1, nmf > 0);
    reset_dut();
    chk("cfg after reset", 32'h51, cfg);
  endtask : s_framing

  task automatic s_one_clock();
    pkt(tdm_port_pkg::KIND_AAL1, 2'h0, 1'b1, 1'b1, 8'h00);
    rx_run <= 1'b1;
    run(400);
    pkt(tdm_port_pkg::KIND_AAL1, 2'h0, 1'b1, 1'b0, 8'h00);
    chk("rx octet ones", 32'h4, $countones(poct));
    rx_run <= 1'b0;
    wb(1'b1, 8'h00, 32'h41, 4'hF);
    run(400);
    pkt(tdm_port_pkg::KIND_AAL1, 2'h0, 1'b1, 1'b0, 8'h00);
    chk("rx octet ones", 32'h4, $countones(poct));
  endtask : s_one_clock

  initial begin
    reset_dut();
    s_reset_values();
    s_fill_regs();
    s_tx_reset();
    s_serial();
    s_framing();
    s_one_clock();
    tally_and_finish();
  end
endmodule : tb_top
